/* File: rbt_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// far-side logic on one bus
// ----------------------------------------------------------------------
module rbt_bus_model
  import rbt_pkg::*;
(
  input wire rbt_pkg::rbt_word_t drive_val, // value the far side puts on the bus
  input wire rbt_pkg::rbt_word_t dev_out,   // device drive value
  input wire rbt_pkg::rbt_word_t dev_oe_n,  // device enable, low = driving
  output var rbt_pkg::rbt_word_t pin        // resolved wire level
);
  // per bit the device wins where it drives; the far side yields to avoid contention
  assign pin = (dev_out & ~dev_oe_n) | (drive_val & dev_oe_n);
endmodule : rbt_bus_model
`default_nettype wire

/* File: rbt_consts.svh */
`ifndef RBT_CONSTS_SVH
`define RBT_CONSTS_SVH
// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define RBT_OFS_CTRL 8'h00
`define RBT_OFS_STORE_A 8'h04
`define RBT_OFS_STORE_B 8'h08
`define RBT_OFS_EVENT 8'h0c
`define RBT_OFS_STATUS 8'h10
// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define RBT_CTRL_RESET 8'h11
`define RBT_CTRL_WIDTH 8
`define RBT_STAT_EMPTY_BIT 0
`define RBT_STAT_FULL_BIT 1
`define RBT_STAT_OVF_BIT 2
`define RBT_EVENT_VALID_BIT 31
// ----------------------------------------------------------------------
// capture record buffer shape
// ----------------------------------------------------------------------
`define RBT_FIFO_WIDTH 20
`define RBT_FIFO_DEPTH 4
`endif

/* File: rbt_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rbt_consts.svh"
module rbt_fifo #(
  parameter int WIDTH = `RBT_FIFO_WIDTH,
  parameter int DEPTH = `RBT_FIFO_DEPTH
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n,   // async reset, low active
  rbt_fifo_if.buffer fif    // fill and drain ports
);
  import rbt_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic do_push, do_pop;

  // ----------------------------------------------------------------------
  // handshakes and pointer update
  // ----------------------------------------------------------------------
  assign fif.push_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign fif.pop_valid = (cnt_reg != '0);
  assign fif.pop_data = mem[rd_reg];
  assign do_push = fif.push_valid & fif.push_ready;
  assign do_pop = fif.pop_valid & fif.pop_ready;

  // next pointers and fill count
  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (do_push) wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    if (do_pop) rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    if (do_push & ~do_pop) cnt_next = cnt_reg + 1'b1;
    else if (do_pop & ~do_push) cnt_next = cnt_reg - 1'b1;
  end

  // pointer registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge clk_sys) begin
    if (do_push) mem[wr_reg] <= fif.push_data;
  end
endmodule : rbt_fifo
`default_nettype wire

/* File: rbt_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
// fill and drain handshakes of the capture record buffer
interface rbt_fifo_if;
  logic push_valid;
  logic push_ready;
  rbt_pkg::rbt_rec_t push_data;
  logic pop_valid;
  logic pop_ready;
  rbt_pkg::rbt_rec_t pop_data;
  modport owner (output push_valid, output push_data, input push_ready,
                 input pop_valid, input pop_data, output pop_ready);
  modport buffer (input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready);
endinterface : rbt_fifo_if
`default_nettype wire

/* File: rbt_pkg.sv */
`include "rbt_consts.svh"
package rbt_pkg;
  // one bus word, both halves
  typedef logic [15:0] rbt_word_t;
  // one bit per 8-bit half
  typedef logic [1:0] rbt_half_t;
  // per-half control, lowest bit first: output enable (low active), direction, selects
  typedef struct packed {
    logic b_to_a_source_select;
    logic a_to_b_source_select;
    logic dir;
    logic oe_n;
  } rbt_half_ctrl_t;
  typedef rbt_half_ctrl_t [1:0] rbt_ctrl_t;
  // capture record: b halves, a halves, data
  typedef logic [`RBT_FIFO_WIDTH-1:0] rbt_rec_t;

  // spreads a per-half mask over the 16 bits
  function automatic rbt_word_t rbt_expand(input rbt_half_t m);
    return {{8{m[1]}}, {8{m[0]}}};
  endfunction : rbt_expand
endpackage : rbt_pkg

/* File: rbt_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rbt_consts.svh"
module rbt_top (
  input wire logic clk_sys,                        // system clock, 25 MHz
  input wire logic rst_n,                          // async reset, low active
  input wire rbt_pkg::rbt_word_t bus_a_in,         // bus A pin level
  output var rbt_pkg::rbt_word_t bus_a_out,        // bus A drive value
  output var rbt_pkg::rbt_word_t bus_a_oe_n,       // bus A drive, low = driving
  input wire rbt_pkg::rbt_word_t bus_b_in,         // bus B pin level
  output var rbt_pkg::rbt_word_t bus_b_out,        // bus B drive value
  output var rbt_pkg::rbt_word_t bus_b_oe_n,       // bus B drive, low = driving
  input wire rbt_pkg::rbt_half_t a_to_b_capture_clock, // per-half A store clock
  input wire rbt_pkg::rbt_half_t b_to_a_capture_clock, // per-half B store clock
  input wire logic psel,                           // apb select
  input wire logic penable,                        // apb access phase
  input wire logic pwrite,                         // apb write
  input wire logic [7:0] paddr,                    // apb byte address
  input wire logic [31:0] pwdata,                  // apb write data
  output logic [31:0] prdata,                      // apb read data
  output logic pready,                             // apb ready
  output logic pslverr                             // apb error
);
  import rbt_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  rbt_word_t a_meta_reg, a_sync_reg, b_meta_reg, b_sync_reg;
  rbt_half_t cab_meta_reg, cab_sync_reg, cab_last_reg;
  rbt_half_t cba_meta_reg, cba_sync_reg, cba_last_reg;
  rbt_half_t ab_edge, ba_edge;
  rbt_word_t store_a_reg, store_a_next, store_b_reg, store_b_next;
  rbt_word_t a_out_reg, a_out_next, b_out_reg, b_out_next;
  rbt_word_t a_oe_n_reg, a_oe_n_next, b_oe_n_reg, b_oe_n_next;
  rbt_ctrl_t ctrl_reg, ctrl_next;
  logic ovf_reg, ovf_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic setup, access_rd, access_wr;
  rbt_fifo_if fif ();

  // ----------------------------------------------------------------------
  // pin sampling: two stages before any logic
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      a_meta_reg <= 16'h0000;
      a_sync_reg <= 16'h0000;
      b_meta_reg <= 16'h0000;
      b_sync_reg <= 16'h0000;
      cab_meta_reg <= 2'h0;
      cab_sync_reg <= 2'h0;
      cab_last_reg <= 2'h0;
      cba_meta_reg <= 2'h0;
      cba_sync_reg <= 2'h0;
      cba_last_reg <= 2'h0;
    end else begin
      a_meta_reg <= bus_a_in;
      a_sync_reg <= a_meta_reg;
      b_meta_reg <= bus_b_in;
      b_sync_reg <= b_meta_reg;
      cab_meta_reg <= a_to_b_capture_clock;
      cab_sync_reg <= cab_meta_reg;
      cab_last_reg <= cab_sync_reg;
      cba_meta_reg <= b_to_a_capture_clock;
      cba_sync_reg <= cba_meta_reg;
      cba_last_reg <= cba_sync_reg;
    end
  end

  // rising edges of the capture clocks, one pulse per edge and half
  assign ab_edge = cab_sync_reg & ~cab_last_reg;
  assign ba_edge = cba_sync_reg & ~cba_last_reg;

  // ----------------------------------------------------------------------
  // capture registers
  // ----------------------------------------------------------------------
  // storage ignores enable and direction, so isolation still captures
  always_comb begin
    store_a_next = (store_a_reg & ~rbt_expand(ab_edge)) | (a_sync_reg & rbt_expand(ab_edge));
    store_b_next = (store_b_reg & ~rbt_expand(ba_edge)) | (b_sync_reg & rbt_expand(ba_edge));
  end

  // a half whose clock holds still keeps its word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      store_a_reg <= 16'h0000;
      store_b_reg <= 16'h0000;
    end else begin
      store_a_reg <= store_a_next;
      store_b_reg <= store_b_next;
    end
  end

  // ----------------------------------------------------------------------
  // output steering, per half
  // ----------------------------------------------------------------------
  // one direction bit picks the single bus a half may drive; registered
  // mux outputs change once per clock, so a select switch never glitches
  always_comb begin
    a_out_next = a_out_reg;
    b_out_next = b_out_reg;
    a_oe_n_next = 16'hffff;
    b_oe_n_next = 16'hffff;
    for (int h = 0; h < 2; h++) begin
      a_out_next[h*8 +: 8] = ctrl_reg[h].b_to_a_source_select ?
                             store_b_reg[h*8 +: 8] : b_sync_reg[h*8 +: 8];
      b_out_next[h*8 +: 8] = ctrl_reg[h].a_to_b_source_select ?
                             store_a_reg[h*8 +: 8] : a_sync_reg[h*8 +: 8];
      if (!ctrl_reg[h].oe_n) begin
        if (ctrl_reg[h].dir) b_oe_n_next[h*8 +: 8] = 8'h00;
        else a_oe_n_next[h*8 +: 8] = 8'h00;
      end
    end
  end

  // drive registers, released at reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      a_out_reg <= 16'h0000;
      b_out_reg <= 16'h0000;
      a_oe_n_reg <= 16'hffff;
      b_oe_n_reg <= 16'hffff;
    end else begin
      a_out_reg <= a_out_next;
      b_out_reg <= b_out_next;
      a_oe_n_reg <= a_oe_n_next;
      b_oe_n_reg <= b_oe_n_next;
    end
  end

  assign bus_a_out = a_out_reg;
  assign bus_b_out = b_out_reg;
  assign bus_a_oe_n = a_oe_n_reg;
  assign bus_b_oe_n = b_oe_n_reg;

  // ----------------------------------------------------------------------
  // capture record buffer
  // ----------------------------------------------------------------------
  // one record per cycle with any store; data is the A word when A stored
  assign fif.push_valid = |{ab_edge, ba_edge};
  assign fif.push_data = {ba_edge, ab_edge, (|ab_edge) ? a_sync_reg : b_sync_reg};

  rbt_fifo #(
    .WIDTH(`RBT_FIFO_WIDTH),
    .DEPTH(`RBT_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fif(fif.buffer)
  );

  // ----------------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------------
  assign setup = psel & ~penable;
  assign access_rd = psel & penable & ~pwrite;
  assign access_wr = psel & penable & pwrite;
  // reading the event word takes the head record out of the buffer
  assign fif.pop_ready = access_rd & (paddr == `RBT_OFS_EVENT);

  // read data and error prepared in the setup cycle
  always_comb begin
    rdata_next = rdata_reg;
    err_next = err_reg;
    ctrl_next = ctrl_reg;
    ovf_next = ovf_reg;
    if (setup) begin
      rdata_next = 32'h0000_0000;
      err_next = 1'b0;
      unique case (paddr)
        `RBT_OFS_CTRL: rdata_next[`RBT_CTRL_WIDTH-1:0] = ctrl_reg;
        `RBT_OFS_STORE_A: rdata_next[15:0] = store_a_reg;
        `RBT_OFS_STORE_B: rdata_next[15:0] = store_b_reg;
        `RBT_OFS_EVENT: begin
          rdata_next[`RBT_EVENT_VALID_BIT] = fif.pop_valid;
          rdata_next[`RBT_FIFO_WIDTH-1:0] = fif.pop_valid ? fif.pop_data : '0;
        end
        `RBT_OFS_STATUS: begin
          rdata_next[`RBT_STAT_EMPTY_BIT] = ~fif.pop_valid;
          rdata_next[`RBT_STAT_FULL_BIT] = ~fif.push_ready;
          rdata_next[`RBT_STAT_OVF_BIT] = ovf_reg;
        end
        default: err_next = 1'b1;
      endcase
    end
    if (access_wr && paddr == `RBT_OFS_CTRL) ctrl_next = pwdata[`RBT_CTRL_WIDTH-1:0];
    if (access_wr && paddr == `RBT_OFS_STATUS && pwdata[`RBT_STAT_OVF_BIT]) ovf_next = 1'b0;
    // a lost record in the same cycle as the clear keeps the flag set
    if (fif.push_valid & ~fif.push_ready) ovf_next = 1'b1;
  end

  // bus-side registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      ctrl_reg <= `RBT_CTRL_RESET;
      ovf_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      ctrl_reg <= ctrl_next;
      ovf_reg <= ovf_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign pslverr = psel & penable & err_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_iso0;
    ctrl_reg[0].oe_n;
  endsequence
  sequence s_b_to_a0;
    !ctrl_reg[0].oe_n && !ctrl_reg[0].dir;
  endsequence
  sequence s_a_to_b1;
    !ctrl_reg[1].oe_n && ctrl_reg[1].dir;
  endsequence

  one_driver_a: assert property ((a_oe_n_reg | b_oe_n_reg) == 16'hffff)
    else $error("both buses driven at once");

  iso_release_a: assert property (s_iso0 |=> (a_oe_n_reg[7:0] == 8'hff) && (b_oe_n_reg[7:0] == 8'hff))
    else $error("half 0 driving while disabled");

  dir_pick_a: assert property (s_a_to_b1 |=> b_oe_n_reg[15:8] == 8'h00 && a_oe_n_reg[15:8] == 8'hff)
    else $error("half 1 drives wrong bus");

  live_to_a_a: assert property (s_b_to_a0 and !ctrl_reg[0].b_to_a_source_select
      |=> a_out_reg[7:0] == $past(b_sync_reg[7:0]) && a_oe_n_reg[7:0] == 8'h00)
    else $error("live B not on bus A");

  stored_to_a_a: assert property (s_b_to_a0 and ctrl_reg[0].b_to_a_source_select
      |=> a_out_reg[7:0] == $past(store_b_reg[7:0]))
    else $error("stored B not on bus A");

  a_to_b_sel_a: assert property (s_a_to_b1 |=> b_out_reg[15:8] == ($past(ctrl_reg[1].a_to_b_source_select) ?
      $past(store_a_reg[15:8]) : $past(a_sync_reg[15:8])))
    else $error("wrong A source on bus B");

  sel_switch_a: assert property (s_b_to_a0 ##1 ($changed(ctrl_reg[0].b_to_a_source_select) and s_b_to_a0)
      |=> a_out_reg[7:0] == ($past(ctrl_reg[0].b_to_a_source_select) ? $past(store_b_reg[7:0])
      : $past(b_sync_reg[7:0])))
    else $error("select change not clean");

  capture_a_a: assert property (ab_edge[1] |=> store_a_reg[15:8] == $past(a_sync_reg[15:8]))
    else $error("A word not stored on clock edge");

  capture_iso_a: assert property (s_iso0 and ba_edge[0] |=> store_b_reg[7:0] == $past(b_sync_reg[7:0]))
    else $error("B word not stored in isolation");

  hold_store_a: assert property (!ab_edge[0] && !ba_edge[0]
      |=> $stable(store_a_reg[7:0]) && $stable(store_b_reg[7:0]))
    else $error("stored word moved without clock edge");

  half_apart_a: assert property (ab_edge == 2'b01 |=> $stable(store_a_reg[15:8]))
    else $error("half 1 stored on half 0 clock");
endmodule : rbt_top
`default_nettype wire

/* File: rbt_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rbt_consts.svh"
`define RBT_CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("unexpected at %0t: got %h want %h", $time, (got), (exp)); \
  end \
end
module rbt_top_tb;
  import rbt_pkg::*;
  // ----------------------------------------------------------------------
  // stimulus values and case table
  // ----------------------------------------------------------------------
  localparam rbt_word_t SA = 16'h3c5a; // stored A pattern
  localparam rbt_word_t SB = 16'hc3a5; // stored B pattern
  localparam rbt_word_t LA = 16'h0f96; // live A pattern
  localparam rbt_word_t LB = 16'h69f0; // live B pattern
  typedef struct packed {
    logic [7:0] ctrl;
    rbt_word_t a_oe_n;
    rbt_word_t b_oe_n;
    rbt_word_t a_out;
    rbt_word_t b_out;
  } rbt_row_t;
  rbt_row_t rows [7];
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  rbt_word_t a_val = 16'h0000;
  rbt_word_t b_val = 16'h0000;
  rbt_word_t bus_a_in, bus_a_out, bus_a_oe_n, bus_b_in, bus_b_out, bus_b_oe_n;
  rbt_half_t clk_ab = 2'h0;
  rbt_half_t clk_ba = 2'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  int err_total = 0;
  int tests_run = 0;
  // ----------------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------------
  always #20 clk_sys = ~clk_sys;
  rbt_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_a_in(bus_a_in), .bus_a_out(bus_a_out),
    .bus_a_oe_n(bus_a_oe_n), .bus_b_in(bus_b_in), .bus_b_out(bus_b_out),
    .bus_b_oe_n(bus_b_oe_n), .a_to_b_capture_clock(clk_ab), .b_to_a_capture_clock(clk_ba),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rbt_bus_model u_far_a (.drive_val(a_val), .dev_out(bus_a_out), .dev_oe_n(bus_a_oe_n),
    .pin(bus_a_in));
  rbt_bus_model u_far_b (.drive_val(b_val), .dev_out(bus_b_out), .dev_oe_n(bus_b_oe_n),
    .pin(bus_b_in));
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  // prints the counts and the verdict, then ends the run
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // one apb transfer: setup, then access held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      report_and_stop();
    end
  endtask : apb
  // reads a word and compares it
  task automatic chk_rd(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    `RBT_CHK(rd, exp)
  endtask : chk_rd
  // raises capture clocks for some cycles so the synchroniser sees them, then lowers them
  task automatic pulse(input rbt_half_t ab, input rbt_half_t ba);
    repeat (4) @(posedge clk_sys);
    clk_ab <= ab;
    clk_ba <= ba;
    repeat (5) @(posedge clk_sys);
    clk_ab <= 2'h0;
    clk_ba <= 2'h0;
    repeat (6) @(posedge clk_sys);
  endtask : pulse
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rows[0] = '{8'h11, 16'hffff, 16'hffff, 16'h0000, 16'h0000};
    rows[1] = '{8'h00, 16'h0000, 16'hffff, LB, 16'h0000};
    rows[2] = '{8'h88, 16'h0000, 16'hffff, SB, 16'h0000};
    rows[3] = '{8'h22, 16'hffff, 16'h0000, 16'h0000, LA};
    rows[4] = '{8'h66, 16'hffff, 16'h0000, 16'h0000, SA};
    rows[5] = '{8'h82, 16'h00ff, 16'hff00, {SB[15:8], 8'h00}, {8'h00, LA[7:0]}};
    rows[6] = '{8'h1e, 16'hffff, 16'hff00, 16'h0000, {8'h00, SA[7:0]}};
    repeat (20) @(posedge clk_sys);
    `RBT_CHK({bus_a_oe_n, bus_b_oe_n}, 32'hffff_ffff)
    rst_n <= 1'b1;
    chk_rd(`RBT_OFS_CTRL, 32'h0000_0011);
    a_val <= SA;
    b_val <= SB;
    pulse(2'h3, 2'h3);
    chk_rd(`RBT_OFS_STORE_A, {16'h0, SA});
    chk_rd(`RBT_OFS_STORE_B, {16'h0, SB});
    chk_rd(`RBT_OFS_EVENT, {16'h800f, SA});
    a_val <= LA;
    b_val <= LB;
    repeat (8) @(posedge clk_sys);
    chk_rd(`RBT_OFS_STORE_A, {16'h0, SA});
    // table of enable, direction and select settings
    foreach (rows[i]) begin
      apb(1'b1, `RBT_OFS_CTRL, {24'h0, rows[i].ctrl});
      repeat (6) @(posedge clk_sys);
      `RBT_CHK({bus_a_oe_n, bus_b_oe_n}, {rows[i].a_oe_n, rows[i].b_oe_n})
      `RBT_CHK(bus_a_out & ~bus_a_oe_n, rows[i].a_out)
      `RBT_CHK(bus_b_out & ~bus_b_oe_n, rows[i].b_out)
      `RBT_CHK(~bus_a_oe_n & ~bus_b_oe_n, 16'h0000)
    end
    // capture while bus B is driven with stored A: only half 0 takes the live value
    apb(1'b1, `RBT_OFS_CTRL, 32'h0000_0066);
    pulse(2'h1, 2'h0);
    `RBT_CHK(bus_b_out, {SA[15:8], LA[7:0]})
    chk_rd(`RBT_OFS_EVENT, {16'h8001, LA});
    // unmapped place and write to a read-only word
    apb(1'b0, 8'h20, 32'h0);
    `RBT_CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, `RBT_OFS_STORE_A, 32'h0000_ffff);
    chk_rd(`RBT_OFS_STORE_A, {16'h0, SA[15:8], LA[7:0]});
    // fill the record buffer past full in isolation, then clear the overflow flag and drain it
    apb(1'b1, `RBT_OFS_CTRL, 32'h0000_0011);
    for (int k = 0; k < 5; k++) begin
      pulse(2'h0, 2'h2);
    end
    chk_rd(`RBT_OFS_STATUS, 32'h0000_0006);
    apb(1'b1, `RBT_OFS_STATUS, 32'h0000_0004);
    chk_rd(`RBT_OFS_STATUS, 32'h0000_0002);
    for (int k = 0; k < 4; k++) begin
      chk_rd(`RBT_OFS_EVENT, {16'h8008, LB});
    end
    chk_rd(`RBT_OFS_STATUS, 32'h0000_0001);
    // reset in mid-run while bus A is driven: bus drives, stored A and control return to their reset values
    apb(1'b1, `RBT_OFS_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `RBT_CHK({bus_a_oe_n, bus_b_oe_n}, 32'hffff_ffff)
    rst_n <= 1'b1;
    chk_rd(`RBT_OFS_STORE_A, 32'h0000_0000);
    chk_rd(`RBT_OFS_CTRL, 32'h0000_0011);
    report_and_stop();
  end
endmodule : rbt_top_tb
`default_nettype wire
